/* design/dpcl_core.sv */
/*
 * Two-port peripheral adapter: control registers, edge flags, interrupt
 * requests, second control line modes and port read paths.
 * Assumes all inputs synchronous to clk; busStrobe marks the falling edge
 * of the processor phase-two clock, one clk cycle wide.
 */
// Functional notes
// - side A control bit 2 picks output register (1) or direction register (0)
// - side A bit 1 picks rising (1) or falling (0) first-input edge for flag 7
// - side A bit 0 gates flag 7 onto the A interrupt request
// - side A bit 5 low: second line is input, edge sets flag 6
// - side A bit 4 selects second line active edge in input mode
// - side A bit 3 enables interrupt from flag 6 in input mode
// - bit 5 high on either side makes bit 6 read as zero
// - side A output mode, bit 4 high: second line follows bit 3
// - side A output mode, bit 4 low: line goes low at port read strobe
// - side A read strobe with bit 3 high returns high next strobe
// - side A handshake: line stays low until next first-input active edge
// - side B control bit 2 picks output register or direction register
// - side B bit 1 picks flag 7 edge; flag cleared by port read or reset
// - side B bit 0 gates flag 7 onto the B interrupt request
// - side B bit 5 low: second line edge sets flag 6, read clears
// - side B bit 4 picks second line edge, bit 3 enables its interrupt
// - side B output mode, bit 4 high: second line follows bit 3
// - side B output mode, bit 4 low: line goes low at port write strobe
// - side B returns high next strobe (bit 3 high) or next first-input edge
// - port A read returns pin levels on every line
// - port B read returns output register for outputs, pins for inputs
// - active-low request asserted while a flag and its enable are set
// - reset clears internal registers to zero; second line outputs and active-low requests reset high
`timescale 1ns/100ps
`include "dpcl_params.svh"

module dpcl_core
    import dpcl_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              busStrobe,
    input  wire logic              chipSelect,
    input  wire logic              readNotWrite,
    input  wire logic [1:0]        registerSelect,
    input  wire logic [7:0]        busDataIn,
    output logic      [7:0]        busDataOut_q,
    output logic                   busDataOe_q,
    input  wire logic [PORT_W-1:0] portAIn,
    output logic      [PORT_W-1:0] portAOut_q,
    output logic      [PORT_W-1:0] portAOe_q,
    input  wire logic [PORT_W-1:0] portBIn,
    output logic      [PORT_W-1:0] portBOut_q,
    output logic      [PORT_W-1:0] portBOe_q,
    input  wire logic              sideAInterruptInput,
    input  wire logic              sideASecondLineIn,
    output logic                   sideASecondLineOut_q,
    output logic                   sideASecondLineOe_q,
    input  wire logic              sideBInterruptInput,
    input  wire logic              sideBSecondLineIn,
    output logic                   sideBSecondLineOut_q,
    output logic                   sideBSecondLineOe_q,
    output logic                   sideAInterruptRequestLow_q,
    output logic                   sideBInterruptRequestLow_q
);

    logic [7:0] ctrlA_q;
    logic [7:0] ctrlB_q;
    logic       flagA1_q;
    logic       flagA2_q;
    logic       flagB1_q;
    logic       flagB2_q;
    logic [3:0] prevLines_q;
    logic       primed_q;
    logic       access;
    logic       rdPortA;
    logic       wrPortB;
    logic       rdPortB;
    logic       edgeA1;
    logic       edgeA2;
    logic       edgeB1;
    logic       edgeB2;
    logic [7:0] ctrlAView;
    logic [7:0] ctrlBView;
    logic [PORT_W-1:0] portBView;
    dpcl_sel_t  sel;

    // edge test on a synchronous line against its previous sample
    function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
        edge_hit = rising ? (!prev && cur) : (prev && !cur);
    endfunction : edge_hit

    // control register as software sees it
    function automatic logic [7:0] ctrl_view(input logic [7:0] cr, input logic f1,
                                             input logic f2);
        ctrl_view = {f1, f2 & ~cr[`DPCL_CR_OUTMODE], cr[5:0]};
    endfunction : ctrl_view

    // access decode on the phase-two falling strobe
    assign sel     = dpcl_sel_t'(registerSelect);
    assign access  = busStrobe && chipSelect;
    assign rdPortA = access && readNotWrite && sel == DPCL_PORT_A
                     && ctrlA_q[`DPCL_CR_ORSEL];
    assign rdPortB = access && readNotWrite && sel == DPCL_PORT_B
                     && ctrlB_q[`DPCL_CR_ORSEL];
    assign wrPortB = access && !readNotWrite && sel == DPCL_PORT_B
                     && ctrlB_q[`DPCL_CR_ORSEL];

    // qualifying edges on the four control lines
    assign edgeA1 = primed_q && edge_hit(prevLines_q[0], sideAInterruptInput,
                                         ctrlA_q[`DPCL_CR_RISE1]);
    assign edgeA2 = primed_q && edge_hit(prevLines_q[1], sideASecondLineIn,
                                         ctrlA_q[`DPCL_CR_CTL4]);
    assign edgeB1 = primed_q && edge_hit(prevLines_q[2], sideBInterruptInput,
                                         ctrlB_q[`DPCL_CR_RISE1]);
    assign edgeB2 = primed_q && edge_hit(prevLines_q[3], sideBSecondLineIn,
                                         ctrlB_q[`DPCL_CR_CTL4]);

    assign ctrlAView = ctrl_view(ctrlA_q, flagA1_q, flagA2_q);
    assign ctrlBView = ctrl_view(ctrlB_q, flagB1_q, flagB2_q);
    assign portBView = (portBOut_q & portBOe_q) | (portBIn & ~portBOe_q);

    // previous line samples; first sample after reset only primes the detector
    always_ff @(posedge clk) begin
        if (rst) begin
            prevLines_q <= 4'h0;
            primed_q    <= 1'b0;
        end else begin
            prevLines_q <= {sideBSecondLineIn, sideBInterruptInput,
                            sideASecondLineIn, sideAInterruptInput};
            primed_q    <= 1'b1;
        end
    end

    // register writes from the processor
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlA_q    <= `DPCL_CR_RESET;
            ctrlB_q    <= `DPCL_CR_RESET;
            portAOut_q <= '0;
            portAOe_q  <= '0;
            portBOut_q <= '0;
            portBOe_q  <= '0;
        end else if (access && !readNotWrite) begin
            case (sel)
                DPCL_PORT_A: begin
                    if (ctrlA_q[`DPCL_CR_ORSEL]) portAOut_q <= busDataIn[PORT_W-1:0];
                    else portAOe_q <= busDataIn[PORT_W-1:0];
                end
                DPCL_CTRL_A: ctrlA_q <= busDataIn & `DPCL_CR_WMASK;
                DPCL_PORT_B: begin
                    if (ctrlB_q[`DPCL_CR_ORSEL]) portBOut_q <= busDataIn[PORT_W-1:0];
                    else portBOe_q <= busDataIn[PORT_W-1:0];
                end
                DPCL_CTRL_B: ctrlB_q <= busDataIn & `DPCL_CR_WMASK;
                default: ctrlA_q <= ctrlA_q;
            endcase
        end
    end

    // read data path, registered at the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            busDataOut_q <= `DPCL_REG_RESET;
            busDataOe_q  <= 1'b0;
        end else begin
            busDataOe_q <= chipSelect && readNotWrite;
            if (access && readNotWrite) begin
                case (sel)
                    DPCL_PORT_A: busDataOut_q <= ctrlA_q[`DPCL_CR_ORSEL] ?
                        8'(portAIn) : 8'(portAOe_q);
                    DPCL_CTRL_A: busDataOut_q <= ctrlAView;
                    DPCL_PORT_B: busDataOut_q <= ctrlB_q[`DPCL_CR_ORSEL] ?
                        8'(portBView) : 8'(portBOe_q);
                    DPCL_CTRL_B: busDataOut_q <= ctrlBView;
                    default: busDataOut_q <= `DPCL_REG_RESET;
                endcase
            end
        end
    end

    // side A flags: a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            flagA1_q <= 1'b0;
            flagA2_q <= 1'b0;
        end else begin
            if (edgeA1) flagA1_q <= 1'b1;
            else if (rdPortA) flagA1_q <= 1'b0;
            if (!ctrlA_q[`DPCL_CR_OUTMODE] && edgeA2) flagA2_q <= 1'b1;
            else if (rdPortA || ctrlA_q[`DPCL_CR_OUTMODE]) flagA2_q <= 1'b0;
        end
    end

    // side B flags: a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            flagB1_q <= 1'b0;
            flagB2_q <= 1'b0;
        end else begin
            if (edgeB1) flagB1_q <= 1'b1;
            else if (rdPortB) flagB1_q <= 1'b0;
            if (!ctrlB_q[`DPCL_CR_OUTMODE] && edgeB2) flagB2_q <= 1'b1;
            else if (rdPortB || ctrlB_q[`DPCL_CR_OUTMODE]) flagB2_q <= 1'b0;
        end
    end

    // active-low interrupt requests
    always_ff @(posedge clk) begin
        if (rst) begin
            sideAInterruptRequestLow_q <= 1'b1;
            sideBInterruptRequestLow_q <= 1'b1;
        end else begin
            sideAInterruptRequestLow_q <= !((flagA1_q && ctrlA_q[`DPCL_CR_EN1]) ||
                (flagA2_q && ctrlA_q[`DPCL_CR_CTL3]));
            sideBInterruptRequestLow_q <= !((flagB1_q && ctrlB_q[`DPCL_CR_EN1]) ||
                (flagB2_q && ctrlB_q[`DPCL_CR_CTL3]));
        end
    end

    // side A second line: manual level, read strobe or handshake
    always_ff @(posedge clk) begin
        if (rst) begin
            sideASecondLineOut_q <= 1'b1;
            sideASecondLineOe_q  <= 1'b0;
        end else begin
            sideASecondLineOe_q <= ctrlA_q[`DPCL_CR_OUTMODE];
            if (!ctrlA_q[`DPCL_CR_OUTMODE]) sideASecondLineOut_q <= 1'b1;
            else if (ctrlA_q[`DPCL_CR_CTL4])
                sideASecondLineOut_q <= ctrlA_q[`DPCL_CR_CTL3];
            else if (rdPortA) sideASecondLineOut_q <= 1'b0;
            else if (ctrlA_q[`DPCL_CR_CTL3] ? busStrobe : edgeA1)
                sideASecondLineOut_q <= 1'b1;
        end
    end

    // side B second line: manual level, write strobe or handshake
    always_ff @(posedge clk) begin
        if (rst) begin
            sideBSecondLineOut_q <= 1'b1;
            sideBSecondLineOe_q  <= 1'b0;
        end else begin
            sideBSecondLineOe_q <= ctrlB_q[`DPCL_CR_OUTMODE];
            if (!ctrlB_q[`DPCL_CR_OUTMODE]) sideBSecondLineOut_q <= 1'b1;
            else if (ctrlB_q[`DPCL_CR_CTL4])
                sideBSecondLineOut_q <= ctrlB_q[`DPCL_CR_CTL3];
            else if (wrPortB) sideBSecondLineOut_q <= 1'b0;
            else if (ctrlB_q[`DPCL_CR_CTL3] ? busStrobe : edgeB1)
                sideBSecondLineOut_q <= 1'b1;
        end
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sAStrobeMode;
        ctrlA_q[`DPCL_CR_OUTMODE] && !ctrlA_q[`DPCL_CR_CTL4];
    endsequence
    sequence sBStrobeMode;
        ctrlB_q[`DPCL_CR_OUTMODE] && !ctrlB_q[`DPCL_CR_CTL4];
    endsequence

    flag_a1_set_a: assert property (edgeA1 |=> flagA1_q)
        else $error("side A flag 7 missed its edge");
    flag_a1_clear_a: assert property (rdPortA && !edgeA1 |=> !flagA1_q)
        else $error("side A flag 7 not cleared by port read");
    flag_b2_set_a: assert property (!ctrlB_q[5] && edgeB2 |=> flagB2_q)
        else $error("side B flag 6 missed its edge");
    irq_a_gate_a: assert property (flagA1_q && ctrlA_q[0] |=> !sideAInterruptRequestLow_q)
        else $error("side A request not asserted");
    irq_b_idle_a: assert property (!flagB1_q && !flagB2_q |=> sideBInterruptRequestLow_q)
        else $error("side B request asserted without flag");
    bit6_zero_a: assert property (access && readNotWrite && sel == DPCL_CTRL_A
        && ctrlA_q[5] |=> !busDataOut_q[6])
        else $error("bit 6 not zero in output mode");
    manual_a_a: assert property (ctrlA_q[5] && ctrlA_q[4] |=> sideASecondLineOut_q == $past(ctrlA_q[3]))
        else $error("side A manual level wrong");
    pulse_a_a: assert property (sAStrobeMode and ctrlA_q[3] && rdPortA
        |=> !sideASecondLineOut_q)
        else $error("side A read strobe did not go low");
    restore_a_a: assert property (sAStrobeMode and ctrlA_q[3] && busStrobe && !rdPortA
        |=> sideASecondLineOut_q)
        else $error("side A read strobe did not restore");
    hshake_a_a: assert property (sAStrobeMode and !ctrlA_q[3] && !sideASecondLineOut_q
        && edgeA1 && !rdPortA |=> sideASecondLineOut_q)
        else $error("side A handshake did not restore");
    wstrobe_b_a: assert property (sBStrobeMode and wrPortB |=> !sideBSecondLineOut_q)
        else $error("side B write strobe did not go low");
    restore_b_a: assert property (sBStrobeMode and ctrlB_q[3] && busStrobe && !wrPortB
        |=> sideBSecondLineOut_q)
        else $error("side B strobe did not restore");
    port_a_read_a: assert property (rdPortA |=> busDataOut_q == 8'($past(portAIn)))
        else $error("port A read not pin levels");
    port_b_read_a: assert property (rdPortB |=> busDataOut_q == 8'($past(portBView)))
        else $error("port B read mix wrong");

endmodule : dpcl_core

/* shared/dpcl_params.svh */
/*
 * Constants for the dual port control line logic: register select codes,
 * control register field positions and reset values.
 * Assumes it is included by bare name after the package.
 */
`ifndef DPCL_PARAMS_SVH
`define DPCL_PARAMS_SVH

// register select codes (two select lines)
`define DPCL_SEL_PORT_A   2'h0
`define DPCL_SEL_CTRL_A   2'h1
`define DPCL_SEL_PORT_B   2'h2
`define DPCL_SEL_CTRL_B   2'h3

// control register field positions
`define DPCL_CR_EN1       0
`define DPCL_CR_RISE1     1
`define DPCL_CR_ORSEL     2
`define DPCL_CR_CTL3      3
`define DPCL_CR_CTL4      4
`define DPCL_CR_OUTMODE   5
`define DPCL_CR_FLAG2     6
`define DPCL_CR_FLAG1     7

// writable part of a control register (bits 5..0)
`define DPCL_CR_WMASK     8'h3f
`define DPCL_CR_RESET     8'h00
`define DPCL_REG_RESET    8'h00

`endif

/* shared/dpcl_pkg.sv */
/*
 * Types for the dual port control line logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dpcl_pkg;

    // register selected by the two select lines
    typedef enum logic [1:0] {
        DPCL_PORT_A = 2'h0,
        DPCL_CTRL_A = 2'h1,
        DPCL_PORT_B = 2'h2,
        DPCL_CTRL_B = 2'h3
    } dpcl_sel_t;

endpackage : dpcl_pkg

/* bench/dpcl_periph_model.sv */
/*
 * Peripheral-side model: drives the port pins, the first control inputs and
 * the released second control lines; answers a strobe by toggling the
 * first control input after a delay when armed.
 * Assumes the bench sets its levels, loads and arming by hierarchical reference.
 */
`timescale 1ns/100ps
module dpcl_periph_model (
    input  wire logic       clk,
    input  wire logic [7:0] portAOut_q,
    input  wire logic [7:0] portAOe_q,
    input  wire logic [7:0] portBOut_q,
    input  wire logic [7:0] portBOe_q,
    input  wire logic       sideASecondLineOut_q,
    input  wire logic       sideASecondLineOe_q,
    input  wire logic       sideBSecondLineOut_q,
    input  wire logic       sideBSecondLineOe_q,
    output logic      [7:0] portAIn,
    output logic      [7:0] portBIn,
    output logic            sideAInterruptInput,
    output logic            sideBInterruptInput,
    output logic            sideASecondLineIn,
    output logic            sideBSecondLineIn
);
    logic [7:0] extA    = 8'h3c; // levels on lines the adapter leaves as inputs
    logic [7:0] extB    = 8'hc3;
    logic [7:0] loadA   = 8'h80; // output lines pulled down by a heavy load
    logic [7:0] loadB   = 8'h04;
    logic [1:0] first   = 2'h0;  // first control input levels, index 0 is side A
    logic [1:0] line    = 2'h3;  // second line levels while the adapter is not driving
    logic [1:0] arm     = 2'h0;  // answer strobes by toggling the first control input
    logic [1:0] prev    = 2'h3;
    int         hsDelay[2] = '{4, 8}; // prompt side A, slow side B
    int         cnt[2]     = '{0, 0};
    wire logic [1:0] lineOut = {sideBSecondLineOut_q, sideASecondLineOut_q};
    wire logic [1:0] lineOe  = {sideBSecondLineOe_q, sideASecondLineOe_q};

    // pins show the adapter where it drives, the peripheral elsewhere
    assign portAIn = (portAOe_q & portAOut_q & ~loadA) | (~portAOe_q & extA);
    assign portBIn = (portBOe_q & portBOut_q & ~loadB) | (~portBOe_q & extB);
    assign sideASecondLineIn = lineOe[0] ? lineOut[0] : line[0];
    assign sideBSecondLineIn = lineOe[1] ? lineOut[1] : line[1];
    assign sideAInterruptInput = first[0];
    assign sideBInterruptInput = first[1];

    // a falling strobe starts the delay, then the first input toggles
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            prev[i] <= lineOut[i];
            if (arm[i] && lineOe[i] && prev[i] && !lineOut[i]) begin
                cnt[i] <= hsDelay[i];
            end else if (cnt[i] == 1) begin
                first[i] <= ~first[i];
                cnt[i] <= 0;
            end else if (cnt[i] > 1) begin
                cnt[i] <= cnt[i] - 1;
            end
        end
    end
endmodule : dpcl_periph_model

/* bench/tb_dual_port_control_line_logic.sv */
/*
 * Self-checking bench: a table of bus accesses, then reset, edge flag,
 * manual output and strobe cases.
 * Assumes the core, its package and header, and the peripheral model.
 */
`timescale 1ns/100ps
`include "dpcl_params.svh"
module tb_dual_port_control_line_logic import dpcl_pkg::*;;
    typedef struct packed {logic rnw; logic [1:0] sel; logic [7:0] d; logic [7:0] e;} dpcl_row_t;
    logic       clk = 1'b0, rst = 1'b1, busStrobe = 1'b0, chipSelect = 1'b0;
    logic       readNotWrite = 1'b0, busDataOe_q;
    logic [1:0] registerSelect = 2'h0;
    logic [7:0] busDataIn = 8'h00, busDataOut_q, portAIn, portAOut_q, portAOe_q;
    logic [7:0] portBIn, portBOut_q, portBOe_q;
    logic       sideAInterruptInput, sideASecondLineIn, sideASecondLineOut_q, sideASecondLineOe_q;
    logic       sideBInterruptInput, sideBSecondLineIn, sideBSecondLineOut_q, sideBSecondLineOe_q;
    logic       sideAInterruptRequestLow_q, sideBInterruptRequestLow_q;
    int         nFail = 0, checked = 0;
    dpcl_row_t  rows[15] = '{'{0, DPCL_CTRL_A, 8'h00, 8'h00}, '{0, DPCL_PORT_A, 8'hf0, 8'h00},
        '{1, DPCL_PORT_A, 8'h00, 8'hf0}, '{0, DPCL_CTRL_A, 8'h04, 8'h00},
        '{0, DPCL_PORT_A, 8'ha5, 8'h00}, '{1, DPCL_CTRL_A, 8'h00, 8'h04},
        '{1, DPCL_PORT_A, 8'h00, 8'h2c}, '{0, DPCL_CTRL_B, 8'h00, 8'h00},
        '{0, DPCL_PORT_B, 8'h0f, 8'h00}, '{1, DPCL_PORT_B, 8'h00, 8'h0f},
        '{0, DPCL_CTRL_B, 8'h04, 8'h00}, '{0, DPCL_PORT_B, 8'h96, 8'h00},
        '{1, DPCL_PORT_B, 8'h00, 8'hc6}, '{0, DPCL_CTRL_A, 8'hff, 8'h00},
        '{1, DPCL_CTRL_A, 8'h00, 8'h3f}};

    // free-running 100 MHz clock
    always #5 clk = ~clk;

    dpcl_core u_dpcl_core (.clk, .rst, .busStrobe, .chipSelect, .readNotWrite, .registerSelect,
        .busDataIn, .busDataOut_q, .busDataOe_q, .portAIn, .portAOut_q, .portAOe_q, .portBIn,
        .portBOut_q, .portBOe_q, .sideAInterruptInput, .sideASecondLineIn, .sideASecondLineOut_q,
        .sideASecondLineOe_q, .sideBInterruptInput, .sideBSecondLineIn, .sideBSecondLineOut_q,
        .sideBSecondLineOe_q, .sideAInterruptRequestLow_q, .sideBInterruptRequestLow_q);
    dpcl_periph_model u_dpcl_periph_model (.clk, .portAOut_q, .portAOe_q, .portBOut_q,
        .portBOe_q, .sideASecondLineOut_q, .sideASecondLineOe_q, .sideBSecondLineOut_q,
        .sideBSecondLineOe_q, .portAIn, .portBIn, .sideAInterruptInput, .sideBInterruptInput,
        .sideASecondLineIn, .sideBSecondLineIn);

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, nFail);
        if (nFail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            nFail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            nFail++;
            $display("[ERR] %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk1

    function automatic logic irqLow(input int s);
        return s ? sideBInterruptRequestLow_q : sideAInterruptRequestLow_q;
    endfunction : irqLow

    function automatic logic lineOf(input int s);
        return s ? sideBSecondLineOut_q : sideASecondLineOut_q;
    endfunction : lineOf

    // one bus access on a strobe; read data is settled on return
    task automatic acc(input logic rnw, input logic [1:0] sel, input logic [7:0] d);
        @(posedge clk);
        busStrobe <= 1'b1;
        chipSelect <= 1'b1;
        readNotWrite <= rnw;
        registerSelect <= sel;
        busDataIn <= d;
        @(posedge clk);
        busStrobe <= 1'b0;
        chipSelect <= 1'b0;
        @(posedge clk);
        #1;
    endtask : acc

    // peripheral sets a control input level, then time for flag and request
    task automatic setLvl(input int s, input int k, input logic v);
        @(posedge clk);
        if (k == 1) begin
            u_dpcl_periph_model.line[s] <= v;
        end else begin
            u_dpcl_periph_model.first[s] <= v;
        end
        repeat (3) @(posedge clk);
    endtask : setLvl

    task automatic edgeCase(input int s, input int k, input logic p);
        logic [7:0] c;
        logic [1:0] sp, sc;
        sp = s ? DPCL_PORT_B : DPCL_PORT_A;
        sc = s ? DPCL_CTRL_B : DPCL_CTRL_A;
        c = 8'h04 | ({7'h0, p} << (k ? 4 : 1)) | ({7'h0, p} << (k ? 3 : 0));
        setLvl(s, k, ~p);
        acc(0, sc, c);
        acc(1, sp, 8'h00);
        setLvl(s, k, p);
        acc(1, sc, 8'h00);
        chk8("flagSet", c | (k ? 8'h40 : 8'h80), busDataOut_q);
        chk1("irqOn", ~p, irqLow(s));
        acc(1, sp, 8'h00);
        setLvl(s, k, ~p);
        acc(1, sc, 8'h00);
        chk8("flagClr", c, busDataOut_q);
        chk1("irqOff", 1'b1, irqLow(s));
    endtask : edgeCase

    task automatic strobeCase(input int s, input logic r3);
        logic [7:0] c;
        logic [1:0] sc;
        int w;
        sc = s ? DPCL_CTRL_B : DPCL_CTRL_A;
        c = 8'h26 | {4'h0, r3, 3'h0};
        setLvl(s, 0, 1'b0);
        acc(0, sc, c);
        if (s) acc(1, DPCL_PORT_B, 8'h00); // side B flag 7 only clears on a port B read
        u_dpcl_periph_model.arm[s] <= ~r3;
        acc(s ? 1'b0 : 1'b1, s ? DPCL_PORT_B : DPCL_PORT_A, 8'h3c);
        chk1("strobeLow", 1'b0, lineOf(s));
        repeat (2) @(posedge clk);
        #1;
        chk1("strobeHold", 1'b0, lineOf(s));
        if (r3) begin
            @(posedge clk);
            busStrobe <= 1'b1;
            @(posedge clk);
            busStrobe <= 1'b0;
        end
        w = 0;
        while (lineOf(s) !== 1'b1 && w < 20) begin
            @(posedge clk);
            #1;
            w++;
        end
        chk1("restore", 1'b1, lineOf(s) === 1'b1 && w <= (r3 ? 2 : 14));
        acc(1, sc, 8'h00);
        chk8("strobeFlag", r3 ? c : c | 8'h80, busDataOut_q);
        u_dpcl_periph_model.arm[s] <= 1'b0;
    endtask : strobeCase

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (rows[i]) begin
            acc(rows[i].rnw, rows[i].sel, rows[i].d);
            if (rows[i].rnw) chk8("table", rows[i].e, busDataOut_q);
        end
        // second reset with registers loaded
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk8("dirA", 8'h00, portAOe_q);
        chk8("outA", 8'h00, portAOut_q);
        chk1("lineA", 1'b1, sideASecondLineOut_q);
        acc(1, DPCL_CTRL_A, 8'h00);
        chk8("ctrlA", 8'h00, busDataOut_q);
        for (int s = 0; s < 2; s++) for (int k = 0; k < 2; k++) for (int p = 0; p < 2; p++)
            edgeCase(s, k, p[0]);
        for (int s = 0; s < 2; s++) for (int v = 0; v < 2; v++) begin
            acc(0, s ? DPCL_CTRL_B : DPCL_CTRL_A, 8'h34 | 8'(v << 3));
            acc(1, s ? DPCL_CTRL_B : DPCL_CTRL_A, 8'h00);
            chk8("manualCtrl", 8'h34 | 8'(v << 3), busDataOut_q);
            chk1("manualLine", v[0], lineOf(s));
        end
        for (int s = 0; s < 2; s++) for (int r = 0; r < 2; r++) strobeCase(s, r[0]);
        conclude();
    end

    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        conclude();
    end
endmodule : tb_dual_port_control_line_logic
